// ---- rtl/dpc_pkg.sv ----
// Constants, field layouts and carrier types for the dual-port counter block.
package dpc_pkg;
    localparam int AW = 18;
    localparam int NPORT = 2;
    localparam logic [AW-1:0] CNT_RST_VAL = 18'h00000;
    localparam logic [AW-1:0] MASK_RST_VAL = 18'h3ffff;
    // Mailbox of port 0 and port 1, the two highest locations.
    localparam logic [AW-1:0] MBOX_ADDR0 = 18'h3fffe;
    localparam logic [AW-1:0] MBOX_ADDR1 = 18'h3ffff;

    // APB register byte offsets.
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_IRQ_MASK = 8'h04;
    localparam logic [7:0] REG_COUNTER0 = 8'h08;
    localparam logic [7:0] REG_COUNTER1 = 8'h0c;
    localparam logic [7:0] REG_CMASK0 = 8'h10;
    localparam logic [7:0] REG_CMASK1 = 8'h14;
    localparam logic [7:0] REG_FLAGS = 8'h18;

    // Status bit positions: terminal events then mailbox-set events.
    localparam int ST_TERM = 0;
    localparam int ST_MBOX = 2;
    localparam int ST_W = 4;

    // Flags register layout.
    localparam int FL_TERM = 0;
    localparam int FL_MBOX = 2;
    localparam int FL_FT = 4;
    localparam int FL_W = 6;

    // Per-port control inputs, driven by logic on clk.
    typedef struct packed {
        logic          counter_clear_input_n;
        logic          load_strobe_n;
        logic          counter_advance_enable_n;
        logic          counter_or_mask_select;
        logic          flow_through_select;
        logic          chip_en;
        logic          read_not_write;
        logic [3:0]    byte_en_n;
        logic [AW-1:0] addr;
    } dpc_pin_t;

    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [7:0]    paddr;
        logic [31:0]   pwdata;
    } dpc_apb_req_t;
endpackage

// ---- rtl/dpc_top.sv ----
// Burst counters, mask registers, flags and global reset of a dual-port RAM.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module dpc_top
    import dpc_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Global reset pin, asynchronous to clk
    input  wire logic                 global_reset_input_n,
    // Per-port control
    input  wire dpc_pkg::dpc_pin_t [1:0] port_in,
    // Per-port outputs
    output logic [1:0]                counter_terminal_flag_n,
    output logic [1:0]                mailbox_flag_n,
    output logic [1:0][dpc_pkg::AW-1:0] counter_out,
    // APB slave
    input  wire dpc_pkg::dpc_apb_req_t apb_req,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Interrupt
    output logic                      irq
);
    import dpc_pkg::*;

    // Three-stage synchroniser; the level moves only when stages 2 and 3 agree.
    logic grst_s1_r, grst_s2_r, grst_s3_r, grst_lvl_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            grst_s1_r <= 1'b0;
            grst_s2_r <= 1'b0;
            grst_s3_r <= 1'b0;
            grst_lvl_r <= 1'b0;
        end else begin
            grst_s1_r <= global_reset_input_n;
            grst_s2_r <= grst_s1_r;
            grst_s3_r <= grst_s2_r;
            if (grst_s2_r == grst_s3_r) begin
                grst_lvl_r <= grst_s3_r;
            end
        end
    end

    // One reset for both ports, held for as long as the pin is low.
    wire core_rst = !nrst || !grst_lvl_r;

    // APB decode.
    wire apb_acc = apb_req.psel && apb_req.penable && pready;
    wire apb_wr = apb_acc && apb_req.pwrite;
    wire [7:0] a = apb_req.paddr;
    wire hit_status = a == REG_STATUS;
    wire hit_imask = a == REG_IRQ_MASK;
    wire hit_known = hit_status || hit_imask || a == REG_COUNTER0 ||
                     a == REG_COUNTER1 || a == REG_CMASK0 ||
                     a == REG_CMASK1 || a == REG_FLAGS;

    logic [AW-1:0]    cnt_r [NPORT];
    logic [AW-1:0]    mask_r [NPORT];
    logic [AW-1:0]    mirror_r [NPORT];
    logic [AW-1:0]    stage_r [NPORT];
    logic [NPORT-1:0] term_ev;
    logic [NPORT-1:0] mbox_set;
    logic [NPORT-1:0] mbox_clr;

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            dpc_pin_t pin;
            assign pin = port_in[p];
            wire cnt_sel = pin.counter_or_mask_select;
            wire op_clear = !pin.counter_clear_input_n;
            wire op_load = !op_clear && !pin.load_strobe_n &&
                           !pin.counter_advance_enable_n;
            wire op_inc = !op_clear && pin.load_strobe_n &&
                          !pin.counter_advance_enable_n;
            // Lowest unmasked bit is the step; a masked bit 0 with bit 1 unmasked counts by two.
            wire [AW-1:0] step = mask_r[p] & (~mask_r[p] + 1'b1);
            wire [AW-1:0] sum = cnt_r[p] + step;
            wire [AW-1:0] inc_val = (cnt_r[p] & ~mask_r[p]) |
                                    (sum & mask_r[p]);
            wire inc_term = (inc_val & mask_r[p]) == mask_r[p];
            assign term_ev[p] = cnt_sel && op_inc && inc_term;

            // Mailbox access needs chip enable and at least one byte lane.
            wire acc = pin.chip_en && (pin.byte_en_n != 4'hf);
            wire [AW-1:0] own_box = (p == 0) ? MBOX_ADDR0 : MBOX_ADDR1;
            wire [AW-1:0] peer_box = (p == 0) ? MBOX_ADDR1 : MBOX_ADDR0;
            wire wr_peer = acc && !pin.read_not_write && pin.addr == peer_box;
            assign mbox_set[1-p] = wr_peer;
            assign mbox_clr[p] = acc && pin.read_not_write &&
                                 pin.addr == own_box;

            always_ff @(posedge clk) begin
                if (core_rst) begin
                    cnt_r[p] <= CNT_RST_VAL;
                    mirror_r[p] <= CNT_RST_VAL;
                    mask_r[p] <= MASK_RST_VAL;
                    counter_terminal_flag_n[p] <= 1'b1;
                end else if (cnt_sel) begin
                    if (op_clear) begin
                        cnt_r[p] <= cnt_r[p] & ~mask_r[p];
                        mirror_r[p] <= mirror_r[p] & ~mask_r[p];
                        counter_terminal_flag_n[p] <= 1'b1;
                    end else if (op_load) begin
                        cnt_r[p] <= pin.addr;
                        mirror_r[p] <= pin.addr;
                        counter_terminal_flag_n[p] <= 1'b1;
                    end else if (op_inc) begin
                        cnt_r[p] <= inc_val;
                        counter_terminal_flag_n[p] <= !inc_term;
                    end
                end else begin
                    // Mask operations: reset to all ones or load from address.
                    if (op_clear) begin
                        mask_r[p] <= MASK_RST_VAL;
                    end else if (op_load) begin
                        mask_r[p] <= pin.addr;
                    end
                end
            end

            // Pipelined mode adds one register stage to the readback path.
            always_ff @(posedge clk) begin
                if (core_rst) begin
                    stage_r[p] <= CNT_RST_VAL;
                    counter_out[p] <= CNT_RST_VAL;
                end else begin
                    stage_r[p] <= cnt_sel ? cnt_r[p] : mask_r[p];
                    counter_out[p] <= pin.flow_through_select ?
                        (cnt_sel ? cnt_r[p] : mask_r[p]) : stage_r[p];
                end
            end

            // A set in the same cycle as the owner's read wins.
            always_ff @(posedge clk) begin
                if (core_rst) begin
                    mailbox_flag_n[p] <= 1'b1;
                end else if (mbox_set[p]) begin
                    mailbox_flag_n[p] <= 1'b0;
                end else if (mbox_clr[p]) begin
                    mailbox_flag_n[p] <= 1'b1;
                end
            end
        end
    endgenerate

    // Sticky status, write one to clear; new events win over the clear.
    logic [ST_W-1:0] status_r;
    logic [ST_W-1:0] imask_r;
    // Nothing is recorded while the core is held in reset.
    wire [ST_W-1:0] events = core_rst ? '0 : {mbox_set, term_ev};
    wire [ST_W-1:0] w1c = (apb_wr && hit_status) ?
                          apb_req.pwdata[ST_W-1:0] : '0;
    wire [ST_W-1:0] status_nxt = (status_r & ~w1c) | events;
    wire [FL_W-1:0] flags = {port_in[1].flow_through_select,
                             port_in[0].flow_through_select,
                             ~mailbox_flag_n, ~counter_terminal_flag_n};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (a)
            REG_STATUS: rd_mux[ST_W-1:0] = status_r;
            REG_IRQ_MASK: rd_mux[ST_W-1:0] = imask_r;
            REG_COUNTER0: rd_mux[AW-1:0] = cnt_r[0];
            REG_COUNTER1: rd_mux[AW-1:0] = cnt_r[1];
            REG_CMASK0: rd_mux[AW-1:0] = mask_r[0];
            REG_CMASK1: rd_mux[AW-1:0] = mask_r[1];
            REG_FLAGS: rd_mux[FL_W-1:0] = flags;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus, status and interrupt use nrst only, so software sees the events
    // left behind by a global reset pulse.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            status_r <= '0;
            imask_r <= '0;
            irq <= 1'b0;
        end else begin
            pready <= apb_req.psel && apb_req.penable && !pready;
            prdata <= rd_mux;
            pslverr <= apb_req.psel && apb_req.penable && !pready &&
                       !hit_known;
            status_r <= status_nxt;
            if (apb_wr && hit_imask) begin
                imask_r <= apb_req.pwdata[ST_W-1:0];
            end
            irq <= |(status_nxt & imask_r);
        end
    end
endmodule

// ---- testbench/dpc_top_asserts.sv ----
// Port-level concurrent checks for the dual-port counter block.
`timescale 1ns/1ps
module dpc_chk
    import dpc_pkg::*;
(
    // Clock and resets
    input logic                   clk,
    input logic                   nrst,
    input logic                   global_reset_input_n,
    // Stimulus seen at the ports
    input dpc_pkg::dpc_pin_t [1:0] port_in,
    input dpc_pkg::dpc_apb_req_t  apb_req,
    // Outputs under check
    input logic [1:0]             counter_terminal_flag_n,
    input logic [1:0]             mailbox_flag_n,
    input logic [1:0][AW-1:0]     counter_out,
    input logic                   pready,
    input logic                   pslverr,
    input logic                   irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire inc0 = port_in[0].counter_or_mask_select
        & port_in[0].counter_clear_input_n & port_in[0].load_strobe_n
        & ~port_in[0].counter_advance_enable_n;
    wire wr1 = port_in[0].chip_en & ~port_in[0].read_not_write
        & ~&port_in[0].byte_en_n & port_in[0].addr == MBOX_ADDR1;
    // The global reset pin is synchronised, so only a settled level counts.
    sequence up6;
        global_reset_input_n [*6];
    endsequence
    a_rst_out: assert property ($rose(nrst) |->
        counter_terminal_flag_n == 2'b11 && mailbox_flag_n == 2'b11
        && !irq && !pready) else $error("outputs wrong after reset");
    a_glob_clr: assert property (!global_reset_input_n [*6] |->
        counter_terminal_flag_n == 2'b11 && mailbox_flag_n == 2'b11
        && counter_out == '0) else $error("global reset left state");
    a_term_fall: assert property (
        $fell(counter_terminal_flag_n[0]) |-> $past(inc0))
        else $error("terminal flag fell without increment");
    a_mbox_set: assert property (up6 ##0 wr1 |=>
        !mailbox_flag_n[1])
        else $error("peer mailbox write did not raise flag");
    a_apb_wait: assert property (apb_req.psel && apb_req.penable
        && !$past(apb_req.penable) |-> !pready ##1 pready)
        else $error("ready not in second access cycle");
    a_ready_one: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    a_ready_qual: assert property (pready |-> apb_req.psel && apb_req.penable)
        else $error("ready outside an access phase");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    c_term: cover property ($fell(counter_terminal_flag_n[0]));
    c_mbox: cover property ($fell(mailbox_flag_n[1]));
    c_err: cover property (pready && pslverr);
endmodule

bind dpc_top dpc_chk i_dpc_chk(.clk(clk), .nrst(nrst),
    .global_reset_input_n(global_reset_input_n), .port_in(port_in),
    .apb_req(apb_req), .counter_terminal_flag_n(counter_terminal_flag_n),
    .mailbox_flag_n(mailbox_flag_n), .counter_out(counter_out),
    .pready(pready), .pslverr(pslverr), .irq(irq));

// ---- testbench/dpc_host.sv ----
// Host controller model that drives one port's counter and mailbox pins.
`timescale 1ns/1ps
module dpc_host
    import dpc_pkg::*;
(
    // Clock
    input logic               clk,
    // Pins of one port
    output dpc_pkg::dpc_pin_t pin
);
    initial pin = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'hf, '0};
    // Pins change only after a rising edge, so each edge sees one command.
    task automatic drive(dpc_pin_t v);
        @(posedge clk) pin <= v;
    endtask
endmodule

// ---- testbench/dpc_top_tb_top.sv ----
// Self-checking bench for the dual-port counter block.
`timescale 1ns/1ps
module dpc_top_tb_top;
    import dpc_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, grst_n = 1'b0, irq, pready, pslverr, err;
    logic [1:0] term_n, mbox_n, ft = '0, tn = 2'b11;
    logic [1:0][AW-1:0] cout;
    logic [31:0] prdata, rd;
    dpc_apb_req_t apb = '0;
    dpc_pin_t pin0, pin1;
    logic [2:0] ops [5] = '{3'b011, 3'b100, 3'b110, 3'b100, 3'b011};
    int error_cnt = 0, n_compared = 0, k, p, mk;
    int cnt[2] = '{0, 0}, msk[2] = '{'h3ffff, 'h3ffff};
    dpc_top i_dpc_top(.clk(clk), .nrst(nrst), .global_reset_input_n(grst_n),
        .port_in({pin1, pin0}), .counter_terminal_flag_n(term_n),
        .mailbox_flag_n(mbox_n), .counter_out(cout), .apb_req(apb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    dpc_host i_h0(.clk(clk), .pin(pin0));
    dpc_host i_h1(.clk(clk), .pin(pin1));
    initial forever #20 clk = ~clk;
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic apb_x(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk) apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk) apb.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        apb <= '0;
    endtask
    task automatic dr(int q, dpc_pin_t v);
        if (q == 0) i_h0.drive(v);
        else i_h1.drive(v);
    endtask
    // One command then idle, so a held increment cannot run away.
    task automatic po(int q, logic [2:0] c, logic s, logic ce, logic rnw,
                      logic [AW-1:0] a);
        int lo;
        lo = msk[q] & -msk[q];
        dr(q, '{c[2], c[1], c[0], s, ft[q], ce, rnw, 4'h0, a});
        dr(q, '{1'b1, 1'b1, 1'b1, s, ft[q], 1'b0, 1'b1, 4'hf, a});
        if (s && !c[2]) cnt[q] &= ~msk[q];
        else if (s && !c[1] && !c[0]) cnt[q] = a;
        else if (s && !c[0])
            cnt[q] = (cnt[q] & ~msk[q]) | ((cnt[q] + lo) & msk[q]);
        else if (!s && !c[2]) msk[q] = 'h3ffff;
        else if (!s && !c[1] && !c[0]) msk[q] = a;
        if (s && (!c[2] || !c[0]))
            tn[q] = !(c[2] && c[1] && (cnt[q] & msk[q]) == msk[q]);
    endtask
    initial begin
        void'($urandom(74422));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        grst_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk("flags", {term_n, mbox_n}, 'hf);
        apb_x(1, REG_IRQ_MASK, 'hf);
        apb_x(0, REG_IRQ_MASK, 0);
        chk("irq mask", rd, 'hf);
        apb_x(1, 8'h40, 'h1);
        chk("unmapped", {rd[30:0], err}, 'h1);
        for (int q = 0; q < 2; q++) begin
            po(q, 3'b100, 1, 0, 1, 18'h3fffe);
            po(q, 3'b110, 1, 0, 1, 0);
            @(posedge clk) #1;
            chk("term", {term_n[q], irq}, 'h1);
            apb_x(0, REG_STATUS, 0);
            chk("status", rd, 1 << (ST_TERM + q));
            apb_x(1, REG_STATUS, 'hf);
        end
        for (int m = 0; m < 2; m++) begin
            ft[0] = m[0];
            po(0, 3'b100, 1, 0, 1, 18'h00123);
            repeat (3) @(posedge clk);
            po(0, 3'b100, 1, 0, 1, 18'h00456);
            @(posedge clk) #1;
            chk("out early", cout[0], m ? 'h456 : 'h123);
            @(posedge clk) #1;
            chk("out late", cout[0], 'h456);
        end
        po(0, 3'b111, 1, 1, 0, MBOX_ADDR0);
        po(0, 3'b111, 1, 1, 0, MBOX_ADDR1);
        @(posedge clk) #1;
        chk("mbox set", {mbox_n, irq}, 3'b011);
        apb_x(0, REG_STATUS, 0);
        chk("mbox status", rd, 1 << (ST_MBOX + 1));
        apb_x(0, REG_FLAGS, 0);
        chk("flag reg", rd, {ft[1], ft[0], 2'b10, ~tn});
        po(1, 3'b111, 1, 1, 1, MBOX_ADDR1);
        apb_x(1, REG_STATUS, 'hf);
        @(posedge clk) #1;
        chk("mbox clear", {mbox_n, irq}, 3'b110);
        po(1, 3'b111, 1, 1, 0, MBOX_ADDR0);
        po(0, 3'b100, 0, 0, 1, 18'h0000f);
        po(0, 3'b100, 1, 0, 1, 18'h2abcd);
        grst_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk("grst", {term_n, mbox_n, |cout}, 'h1e);
        @(posedge clk) grst_n <= 1'b1;
        cnt = '{0, 0};
        msk = '{'h3ffff, 'h3ffff};
        tn = 2'b11;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 30; i++) begin
            p = $urandom % 2;
            k = $urandom % 5;
            mk = (1 << (1 + $urandom % 18)) - 1;
            po(p, ops[k], k < 3, 0, 1, k == 3 ? 18'(mk) : 18'($urandom));
            apb_x(0, REG_COUNTER0 + 8'(4 * p), 0);
            chk("count", rd, cnt[p]);
            apb_x(0, REG_CMASK0 + 8'(4 * p), 0);
            chk("mask", rd, msk[p]);
            chk("readback", cout[p], k < 3 ? cnt[p] : msk[p]);
            chk("term flag", term_n[p], tn[p]);
        end
        tally_and_finish();
    end
endmodule
